// ==== rtl/rtc_control_status_regs.sv ====
// control and status registers of a battery-backed real-time clock
`include "rtc_ctrl_defines.svh"

module rtc_control_status_regs
	import rtc_ctrl_pkg::*;
#(
	parameter int unsigned OSC_HZ       = `RTC_OSC_HZ,
	parameter int unsigned CONVERT_REQUEST_SEC_BAT = `RTC_CONVERT_REQUEST_SEC_BAT
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       osc_clk_i,
	input  wire logic       vcc_below_pf_i,
	input  wire logic       osc_running_i,
	input  wire logic       alarm1_match_i,
	input  wire logic       alarm2_match_i,
	input  wire logic       convert_request_done_i,
	output logic            osc_enable_o,
	output logic            sec_tick_o,
	output logic            convert_request_start_o,
	output logic            comp_run_o,
	output logic            interrupt_square_wave_pin_o,
	output logic            interrupt_square_wave_pin_oe_o,
	output logic            khz_out_o,
	output logic            khz_oe_o
);

	localparam int unsigned HALF_SEC = OSC_HZ / 2;
	localparam int unsigned CW       = $clog2(OSC_HZ);
	localparam int unsigned SW       = $clog2(CONVERT_REQUEST_SEC_BAT + 1);

	// synchronisers: [0] osc clock, [1] supply low, [2] oscillator running
	logic [2:0] meta_ff;
	logic [2:0] sync_ff;
	logic       osc_prev_ff;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_ff     <= 3'h0;
			sync_ff     <= 3'h0;
			osc_prev_ff <= 1'b0;
		end else begin
			meta_ff     <= {osc_running_i, vcc_below_pf_i, osc_clk_i};
			sync_ff     <= meta_ff;
			osc_prev_ff <= sync_ff[0];
		end
	end

	logic on_battery;
	logic osc_rise;
	assign on_battery = sync_ff[1];
	assign osc_rise   = sync_ff[0] & ~osc_prev_ff;

	control_t      ctrl_ff;
	status_flags_t stat_ff;
	convert_request_state_t   convert_request_state_ff;
	logic          osc_en;
	logic          wr_ctrl;
	logic          wr_stat;
	control_t      wctrl;
	status_flags_t wstat;

	assign wr_ctrl = reg_wr_i && (reg_addr_i == `RTC_ADDR_CONTROL);
	assign wr_stat = reg_wr_i && (reg_addr_i == `RTC_ADDR_STATUS);
	assign wctrl   = control_t'(reg_wdata_i);
	assign wstat   = status_flags_t'(reg_wdata_i);

	// oscillator stops only on battery with disable set
	assign osc_en = ~(ctrl_ff.osc_disable_on_battery & on_battery);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			osc_enable_o <= 1'b1;
		end else begin
			osc_enable_o <= osc_en;
		end
	end

	// half-second divider on the oscillator edges, frozen while stopped
	logic [CW-1:0] div_ff;
	logic          sq_ff;
	logic          sec_tick_ff;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_ff      <= '0;
			sq_ff       <= 1'b1;
			sec_tick_ff <= 1'b0;
		end else begin
			sec_tick_ff <= 1'b0;
			if (osc_en && osc_rise) begin
				if (div_ff == CW'(HALF_SEC - 1)) begin
					div_ff      <= '0;
					sq_ff       <= ~sq_ff;
					sec_tick_ff <= sq_ff;
				end else begin
					div_ff <= div_ff + 1'b1;
				end
			end
		end
	end

	assign sec_tick_o = sec_tick_ff;

	// periodic conversion schedule, counted in seconds only
	logic [SW-1:0] sched_ff;
	logic          periodic_due_ff;
	logic          sched_hit;
	logic          start_convert_request;
	logic          user_waiting;
	logic          user_active_ff;

	assign sched_hit = sec_tick_ff &&
		(on_battery ? (sched_ff >= SW'(CONVERT_REQUEST_SEC_BAT - 1)) : (SW'(`RTC_CONVERT_REQUEST_SEC_VCC) == SW'(1)));
	// one conversion may serve a due periodic run and a user request at once
	assign user_waiting = ctrl_ff.convert_request & ~user_active_ff;
	assign start_convert_request   = (convert_request_state_ff == CONVERT_REQUEST_IDLE) && osc_en &&
		(periodic_due_ff || user_waiting);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sched_ff        <= '0;
			periodic_due_ff <= 1'b1;
		end else begin
			if (sec_tick_ff) begin
				sched_ff <= sched_hit ? '0 : sched_ff + 1'b1;
			end
			if (sched_hit) begin
				periodic_due_ff <= 1'b1;
			end else if (start_convert_request) begin
				periodic_due_ff <= 1'b0;
			end
		end
	end

	// conversion sequencer
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			convert_request_state_ff  <= CONVERT_REQUEST_IDLE;
			user_active_ff <= 1'b0;
			convert_request_start_o   <= 1'b0;
		end else begin
			convert_request_start_o <= 1'b0;
			unique case (convert_request_state_ff)
				CONVERT_REQUEST_IDLE: begin
					if (start_convert_request) begin
						convert_request_state_ff  <= CONVERT_REQUEST_RUN;
						user_active_ff <= ctrl_ff.convert_request;
						convert_request_start_o   <= 1'b1;
					end
				end
				CONVERT_REQUEST_RUN: begin
					if (convert_request_done_i) begin
						convert_request_state_ff  <= CONVERT_REQUEST_IDLE;
						user_active_ff <= 1'b0;
					end
				end
			endcase
		end
	end

	// compensation gate: one run per second at most
	logic comp_pending_ff;
	logic comp_allow_ff;
	logic comp_go;
	assign comp_go = comp_pending_ff && comp_allow_ff && osc_en;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			comp_pending_ff <= 1'b0;
			comp_allow_ff   <= 1'b1;
			comp_run_o      <= 1'b0;
		end else begin
			comp_run_o <= comp_go;
			// a result finished on the run edge stays pending
			if (convert_request_done_i && convert_request_state_ff == CONVERT_REQUEST_RUN) begin
				comp_pending_ff <= 1'b1;
			end else if (comp_go) begin
				comp_pending_ff <= 1'b0;
			end
			// a run on the tick edge spends the new second's allowance
			if (comp_go) begin
				comp_allow_ff <= 1'b0;
			end else if (sec_tick_ff) begin
				comp_allow_ff <= 1'b1;
			end
		end
	end

	// control register
	logic convert_request_finish;
	assign convert_request_finish = (convert_request_state_ff == CONVERT_REQUEST_RUN) && convert_request_done_i && user_active_ff;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_ff <= control_t'(`RTC_CTRL_RESET);
		end else begin
			if (wr_ctrl) begin
				ctrl_ff.osc_disable_on_battery     <= wctrl.osc_disable_on_battery;
				ctrl_ff.battery_square_wave_enable <= wctrl.battery_square_wave_enable;
				ctrl_ff.unused_ctrl_bits           <= wctrl.unused_ctrl_bits;
				ctrl_ff.interrupt_control          <= wctrl.interrupt_control;
				ctrl_ff.second_alarm_enable        <= wctrl.second_alarm_enable;
				ctrl_ff.first_alarm_enable         <= wctrl.first_alarm_enable;
			end
			// convert rises only on a written 1, falls when its own conversion ends
			if (wr_ctrl && wctrl.convert_request && !ctrl_ff.convert_request) begin
				ctrl_ff.convert_request <= 1'b1;
			end else if (convert_request_finish) begin
				ctrl_ff.convert_request <= 1'b0;
			end
		end
	end

	// status register; hardware sets win over software clears
	logic stop_seen;
	logic a1_set;
	logic a2_set;
	assign stop_seen = ~sync_ff[2] | ~osc_en;
	assign a1_set    = alarm1_match_i & sec_tick_ff & osc_en;
	assign a2_set    = alarm2_match_i & sec_tick_ff & osc_en;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			stat_ff <= status_flags_t'(`RTC_STAT_RESET);
		end else begin
			stat_ff.zero_bits <= 3'h0;
			stat_ff.busy      <= 1'b0;
			// level set: repeats while the oscillator stays down
			if (stop_seen) begin
				stat_ff.oscillator_stop_flag <= 1'b1;
			end else if (wr_stat && !wstat.oscillator_stop_flag) begin
				stat_ff.oscillator_stop_flag <= 1'b0;
			end
			if (wr_stat) begin
				stat_ff.khz_output_enable <= wstat.khz_output_enable;
			end
			if (a2_set) begin
				stat_ff.second_alarm_flag <= 1'b1;
			end else if (wr_stat && !wstat.second_alarm_flag) begin
				stat_ff.second_alarm_flag <= 1'b0;
			end
			if (a1_set) begin
				stat_ff.first_alarm_flag <= 1'b1;
			end else if (wr_stat && !wstat.first_alarm_flag) begin
				stat_ff.first_alarm_flag <= 1'b0;
			end
		end
	end

	// register read port, one cycle behind the address
	status_flags_t stat_rd;
	always_comb begin
		stat_rd           = stat_ff;
		// busy and the zero bits are live, never taken from storage
		stat_rd.zero_bits = 3'h0;
		stat_rd.busy      = (convert_request_state_ff == CONVERT_REQUEST_RUN);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_addr_i == `RTC_ADDR_CONTROL) begin
			reg_rdata_o <= ctrl_ff;
		end else if (reg_addr_i == `RTC_ADDR_STATUS) begin
			reg_rdata_o <= stat_rd;
		end else begin
			reg_rdata_o <= `RTC_ADDR_UNMAPPED_RD;
		end
	end

	// shared interrupt / square-wave pin, open drain
	logic alarm_irq;
	logic nxt_int_oe;
	assign alarm_irq =
		(stat_ff.second_alarm_flag & ctrl_ff.second_alarm_enable) |
		(stat_ff.first_alarm_flag & ctrl_ff.first_alarm_enable);

	always_comb begin
		// on battery with the wave disabled the pin is released, alarms too
		if (on_battery && !ctrl_ff.battery_square_wave_enable) begin
			nxt_int_oe = 1'b0;
		end else if (ctrl_ff.interrupt_control) begin
			nxt_int_oe = alarm_irq;
		end else begin
			nxt_int_oe = ~sq_ff;
		end
	end

	logic int_oe_ff;
	logic khz_out_ff;
	logic khz_oe_ff;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			int_oe_ff  <= 1'b0;
			khz_out_ff <= 1'b0;
			khz_oe_ff  <= 1'b1;
		end else begin
			int_oe_ff  <= nxt_int_oe;
			// 32k output follows the synced time base, held low while stopped
			khz_out_ff <= sync_ff[0] & osc_en;
			khz_oe_ff  <= stat_ff.khz_output_enable;
		end
	end

	assign interrupt_square_wave_pin_o    = 1'b0;
	assign interrupt_square_wave_pin_oe_o = int_oe_ff;
	assign khz_out_o    = khz_out_ff;
	assign khz_oe_o     = khz_oe_ff;

endmodule // rtc_control_status_regs

// ==== rtl/rtc_ctrl_defines.svh ====
// register offsets, reset values and timing figures of the rtc control block
`ifndef RTC_CTRL_DEFINES_SVH
`define RTC_CTRL_DEFINES_SVH

`define RTC_ADDR_CONTROL     8'h0e
`define RTC_ADDR_STATUS      8'h0f
`define RTC_ADDR_UNMAPPED_RD 8'h00

// control: disable 0, bbsq 0, convert_request 0, unused 11, interrupt_control 1, enables 00
`define RTC_CTRL_RESET       8'h1c
// status: stop flag 1, 32k enable 1, flags 0
`define RTC_STAT_RESET       8'h88

// oscillator time base in hertz
`define RTC_OSC_HZ           32768
// periodic conversion interval in seconds on main supply and on battery
`define RTC_CONVERT_REQUEST_SEC_VCC     1
`define RTC_CONVERT_REQUEST_SEC_BAT     10
// least time between compensation runs in seconds
`define RTC_COMP_MIN_SEC     1

`endif

// ==== rtl/rtc_ctrl_pkg.sv ====
// types shared by the rtc control and status block
package rtc_ctrl_pkg;

	typedef struct packed {
		logic       osc_disable_on_battery;
		logic       battery_square_wave_enable;
		logic       convert_request;
		logic [1:0] unused_ctrl_bits;
		logic       interrupt_control;
		logic       second_alarm_enable;
		logic       first_alarm_enable;
	} control_t;

	typedef struct packed {
		logic       oscillator_stop_flag;
		logic [2:0] zero_bits;
		logic       khz_output_enable;
		logic       busy;
		logic       second_alarm_flag;
		logic       first_alarm_flag;
	} status_flags_t;

	typedef enum logic [1:0] {
		CONVERT_REQUEST_IDLE = 2'b01,
		CONVERT_REQUEST_RUN  = 2'b10
	} convert_request_state_t;

endpackage

// ==== verif/rtc_ctrl_monitor.sv ====
// assertions on the ports of the rtc control and status block
module rtc_ctrl_monitor #(
	parameter int unsigned OSC_HZ       = 8,
	parameter int unsigned CONVERT_REQUEST_SEC_BAT = 2
) (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       vcc_below_pf_i,
	input wire logic       convert_request_done_i,
	input wire logic       osc_enable_o,
	input wire logic       sec_tick_o,
	input wire logic       convert_request_start_o,
	input wire logic       comp_run_o,
	input wire logic       interrupt_square_wave_pin_oe_o,
	input wire logic       khz_out_o
);
	logic [2:0] ctl_ff;
	logic       run_ff;
	logic       pend_ff;
	logic       comp_ff;
	logic       done_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// shadow of the interrupt control and alarm enables
	always_ff @(posedge clk_i)
		if (reset_i) ctl_ff <= 3'h4;
		else if (reg_wr_i && reg_addr_i == 8'h0e) ctl_ff <= reg_wdata_i[2:0];
	always_ff @(posedge clk_i)
		if (reset_i) run_ff <= 1'b0;
		else if (convert_request_start_o) run_ff <= 1'b1;
		else if (convert_request_done_i) run_ff <= 1'b0;
	always_ff @(posedge clk_i)
		if (reset_i) pend_ff <= 1'b0;
		else if (convert_request_done_i && run_ff) pend_ff <= 1'b1;
		else if (comp_run_o && !done_q) pend_ff <= 1'b0;
	// a run launched on a done edge leaves the new result pending
	always_ff @(posedge clk_i)
		done_q <= !reset_i && convert_request_done_i && run_ff;
	always_ff @(posedge clk_i)
		if (reset_i || sec_tick_o) comp_ff <= 1'b0;
		else if (comp_run_o) comp_ff <= 1'b1;
	chk_osc_on_mains: assert property (!vcc_below_pf_i [*4] |-> osc_enable_o)
		else $error("oscillator stopped on main supply");
	chk_khz_gated: assert property (!osc_enable_o |-> !khz_out_o)
		else $error("32k output runs with oscillator off");
	chk_tick_gap: assert property (sec_tick_o |=> !sec_tick_o [*8])
		else $error("second ticks too close");
	chk_int_masked: assert property (ctl_ff == 3'h4 [*3] |-> !interrupt_square_wave_pin_oe_o)
		else $error("interrupt pin active with alarms disabled");
	chk_convert_request_single: assert property (convert_request_start_o |-> !run_ff)
		else $error("conversion started while busy");
	chk_comp_after_done: assert property (comp_run_o |-> pend_ff)
		else $error("compensation without finished conversion");
	chk_comp_once: assert property (comp_run_o |-> !comp_ff)
		else $error("compensation twice in one second");
	chk_status_zero: assert property (reg_addr_i == 8'h0f |=> reg_rdata_o[6:4] == 3'h0)
		else $error("unused status bits not zero");
endmodule // rtc_ctrl_monitor

bind rtc_control_status_regs rtc_ctrl_monitor #(
	.OSC_HZ      (OSC_HZ),
	.CONVERT_REQUEST_SEC_BAT(CONVERT_REQUEST_SEC_BAT)
) u_monitor (
	.clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
	.vcc_below_pf_i, .convert_request_done_i, .osc_enable_o, .sec_tick_o, .convert_request_start_o,
	.comp_run_o, .interrupt_square_wave_pin_oe_o, .khz_out_o
);

// ==== verif/rtc_far_side_model.sv ====
// oscillator and temperature sensor beside the rtc control block
module rtc_far_side_model (
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic osc_enable_i,
	input  wire logic convert_request_start_i,
	output logic      osc_clk_o,
	output logic      osc_running_o,
	output logic      convert_request_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] convert_request_cnt_ff;
	// time base stands still while disabled
	initial begin
		osc_clk_o = 1'b0;
		#137;
		forever begin
			#400;
			if (osc_enable_i) osc_clk_o = ~osc_clk_o;
		end
	end
	always_ff @(posedge clk_i)
		osc_running_o <= reset_i | osc_enable_i;
	always_ff @(posedge clk_i)
		if (reset_i) convert_request_cnt_ff <= 4'h0;
		else if (convert_request_start_i) convert_request_cnt_ff <= 4'h6;
		else if (convert_request_cnt_ff != 4'h0) convert_request_cnt_ff <= convert_request_cnt_ff - 4'h1;
	assign convert_request_done_o = convert_request_cnt_ff == 4'h1;
endmodule // rtc_far_side_model

// ==== verif/rtc_control_status_regs_test.sv ====
// self-checking bench of the rtc control and status block
module rtc_control_status_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] mask;
		logic [7:0] exp;
	} row_t;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        vcc_below_pf_i = 1'b0;
	logic        alarm1_match_i = 1'b0;
	logic        alarm2_match_i = 1'b0;
	logic [7:0]  reg_rdata_o, v;
	logic        osc_clk_i, osc_running_i, convert_request_done_i, osc_enable_o, sec_tick_o, seen;
	logic        convert_request_start_o, comp_run_o, interrupt_square_wave_pin_o, interrupt_square_wave_pin_oe_o, khz_out_o, khz_oe_o;
	int          n_errors = 0;
	int          num_checks = 0;
	logic [15:0] bat [3] = '{16'h4001, 16'h0000, 16'h8000};
	row_t        rows [5] = '{'{8'h0e, 8'h18, 8'hff, 8'h18}, '{8'h0e, 8'h07, 8'hff, 8'h07},
		'{8'h0f, 8'h00, 8'hfb, 8'h00}, '{8'h0f, 8'h7b, 8'hfb, 8'h08},
		'{8'h05, 8'hff, 8'hff, 8'h00}};
	always #50 clk_i = ~clk_i;
	rtc_control_status_regs #(.OSC_HZ(8), .CONVERT_REQUEST_SEC_BAT(2)) DUT (
		.clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
		.osc_clk_i, .vcc_below_pf_i, .osc_running_i, .alarm1_match_i, .alarm2_match_i,
		.convert_request_done_i, .osc_enable_o, .sec_tick_o, .convert_request_start_o, .comp_run_o,
		.interrupt_square_wave_pin_o, .interrupt_square_wave_pin_oe_o, .khz_out_o, .khz_oe_o);
	rtc_far_side_model far (.clk_i, .reset_i, .osc_enable_i(osc_enable_o),
		.convert_request_start_i(convert_request_start_o), .osc_clk_o(osc_clk_i),
		.osc_running_o(osc_running_i), .convert_request_done_o(convert_request_done_i));
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wr_i <= 1'b1;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		repeat (2) @(posedge clk_i);
		#1 v = reg_rdata_o;
	endtask
	task automatic watch(int n);
		repeat (3) @(posedge clk_i);
		seen = 1'b0;
		repeat (n) @(posedge clk_i) seen |= interrupt_square_wave_pin_oe_o;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		rd(8'h0e);
		chk("control reset", v, 8'h1c);
		rd(8'h0f);
		chk("status reset", v & 8'hfb, 8'h88);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].data);
			rd(rows[i].addr);
			chk("row read", v & rows[i].mask, rows[i].exp);
		end
		$display("register rows done");
		@(posedge sec_tick_o);
		repeat (12) @(posedge clk_i);
		wr(8'h0e, 8'h27);
		rd(8'h0e);
		chk("convert set", v & 8'h20, 8'h20);
		for (int k = 0; k < 200 && v[5] !== 1'b0; k++) rd(8'h0e);
		chk("convert clear", v, 8'h07);
		rd(8'h0f);
		chk("busy clear", v & 8'h04, 8'h00);
		$display("conversion done");
		for (int i = 0; i < 2; i++) begin
			wr(8'h0e, 8'h05);
			alarm1_match_i <= (i == 0);
			alarm2_match_i <= (i == 1);
			repeat (70) @(posedge clk_i);
			alarm1_match_i <= 1'b0;
			alarm2_match_i <= 1'b0;
			rd(8'h0f);
			chk("alarm flag", v & 8'h03, 8'(i + 1));
			chk("alarm pin", {7'h0, interrupt_square_wave_pin_oe_o}, 8'(i == 0));
			chk("pin data", {7'h0, interrupt_square_wave_pin_o}, 8'h00);
			wr(8'h0f, 8'h08 | 8'(2 - i));
			rd(8'h0f);
			chk("flag clear", v & 8'h03, 8'h00);
			chk("pin release", {7'h0, interrupt_square_wave_pin_oe_o}, 8'h00);
		end
		$display("alarm tests done");
		@(posedge clk_i);
		vcc_below_pf_i <= 1'b1;
		foreach (bat[i]) begin
			wr(8'h0e, bat[i][15:8]);
			watch(150);
			chk("battery pin", {7'h0, seen}, bat[i][7:0]);
		end
		chk("osc off", {7'h0, osc_enable_o}, 8'h00);
		rd(8'h0f);
		chk("stop flag", v & 8'h80, 8'h80);
		@(posedge clk_i);
		vcc_below_pf_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk("osc on", {7'h0, osc_enable_o}, 8'h01);
		wr(8'h0f, 8'h00);
		rd(8'h0f);
		chk("stop clear", v & 8'h80, 8'h00);
		chk("khz off", {7'h0, khz_oe_o}, 8'h00);
		$display("battery tests done");
		finish_test;
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		finish_test;
	end
endmodule // rtc_control_status_regs_test
